// >>> hw/pcihs_map.vh
// constants for the pci handshake, stop and config-select block
// assumes a single 250 MHz bus clock; included by bare name
`ifndef PCIHS_MAP_VH
`define PCIHS_MAP_VH
`define PCIHS_CMD_CFG_RD 4'hA
`define PCIHS_CMD_CFG_WR 4'hB
`define PCIHS_ST_IDLE 3'h0
`define PCIHS_ST_TGT 3'h1
`define PCIHS_ST_TGT_END 3'h2
`define PCIHS_ST_INI 3'h3
`define PCIHS_ST_INI_END 3'h4
`define PCIHS_DEF_WAIT 4'h2
`define PCIHS_OUT_RST 1'h1
`define PCIHS_OE_RST 1'h0
`endif

// >>> hw/pcihs_cfg_decode.v
// address-phase decode for configuration accesses
// assumes bus inputs are synchronous to clock_in
`timescale 1ns/100ps
`default_nettype none
`include "pcihs_map.vh"
module pcihs_cfg_decode (
  input wire clock_in,
  input wire arst_n_in,
  input wire addr_phase_in,
  input wire init_dev_select_in,
  input wire [3:0] command_byte_enable_n_in,
  output reg cfg_hit_out,
  output reg cfg_write_out
);
  wire is_cfg;
  // standard pci command codes on the c/be lines
  assign is_cfg = (command_byte_enable_n_in == `PCIHS_CMD_CFG_RD) ||
                  (command_byte_enable_n_in == `PCIHS_CMD_CFG_WR);
  // registered: select sampled only on the rising edge
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_hit_out <= 1'b0;
      cfg_write_out <= 1'b0;
    end else begin
      cfg_hit_out <= addr_phase_in & init_dev_select_in & is_cfg;
      cfg_write_out <= command_byte_enable_n_in == `PCIHS_CMD_CFG_WR;
    end
  end
endmodule // pcihs_cfg_decode
`default_nettype wire

// >>> hw/pcihs_core.v
// initiator-ready handshake, stop request and config select for the pci port
// assumes all bus inputs synchronous to clock_in; tri-state resolved outside
`timescale 1ns/100ps
`default_nettype none
`include "pcihs_map.vh"
module pcihs_core #(
  parameter [3:0] TGT_WAIT = `PCIHS_DEF_WAIT
) (
  input wire clock_in,
  input wire arst_n_in,
  input wire cycle_frame_n_in,
  input wire initiator_ready_n_in,
  input wire target_ready_n_in,
  input wire stop_request_n_in,
  input wire init_dev_select_in,
  input wire [3:0] command_byte_enable_n_in,
  input wire ini_start_in,
  input wire ini_ready_in,
  input wire ini_last_in,
  output reg cycle_frame_n_out,
  output reg cycle_frame_n_oe_out,
  output reg initiator_ready_n_out,
  output reg initiator_ready_n_oe_out,
  output reg target_ready_n_out,
  output reg target_ready_n_oe_out,
  output reg stop_request_n_out,
  output reg stop_request_n_oe_out,
  output reg device_select_n_out,
  output reg device_select_n_oe_out,
  output reg cfg_access_out,
  output reg cfg_write_out,
  output reg data_done_out,
  output reg ini_stopped_out,
  output reg ini_busy_out
);
  reg [2:0] st_q;
  reg frame_prev_q;
  reg [3:0] wait_q;
  reg first_q;
  wire addr_phase;
  wire cfg_hit;
  wire cfg_wr;
  wire frame_ours;
  wire frame_seen;
  wire irdy_seen;
  wire done;
  // our own frame counts while we drive it; inputs are registered at the edge
  assign frame_ours = cycle_frame_n_oe_out ? cycle_frame_n_out : cycle_frame_n_in;
  assign frame_seen = frame_ours;
  assign irdy_seen = initiator_ready_n_oe_out ? initiator_ready_n_out : initiator_ready_n_in;
  assign addr_phase = frame_prev_q & ~cycle_frame_n_in & (st_q == `PCIHS_ST_IDLE);
  assign done = ~irdy_seen & ~target_ready_n_in & (st_q != `PCIHS_ST_IDLE);
  pcihs_cfg_decode u_dec (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .addr_phase_in(addr_phase),
    .init_dev_select_in(init_dev_select_in),
    .command_byte_enable_n_in(command_byte_enable_n_in),
    .cfg_hit_out(cfg_hit),
    .cfg_write_out(cfg_wr)
  );
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= `PCIHS_ST_IDLE;
      frame_prev_q <= 1'b1;
      wait_q <= 4'h0;
      first_q <= 1'b0;
      cycle_frame_n_out <= `PCIHS_OUT_RST;
      cycle_frame_n_oe_out <= `PCIHS_OE_RST;
      initiator_ready_n_out <= `PCIHS_OUT_RST;
      initiator_ready_n_oe_out <= `PCIHS_OE_RST;
      target_ready_n_out <= `PCIHS_OUT_RST;
      target_ready_n_oe_out <= `PCIHS_OE_RST;
      stop_request_n_out <= `PCIHS_OUT_RST;
      stop_request_n_oe_out <= `PCIHS_OE_RST;
      device_select_n_out <= `PCIHS_OUT_RST;
      device_select_n_oe_out <= `PCIHS_OE_RST;
      cfg_access_out <= 1'b0;
      cfg_write_out <= 1'b0;
      data_done_out <= 1'b0;
      ini_stopped_out <= 1'b0;
      ini_busy_out <= 1'b0;
    end else begin
      frame_prev_q <= frame_seen;
      data_done_out <= done;
      cfg_access_out <= 1'b0;
      ini_stopped_out <= 1'b0;
      case (st_q)
        `PCIHS_ST_IDLE: begin
          // not involved: all shared outputs float
          initiator_ready_n_oe_out <= 1'b0;
          stop_request_n_oe_out <= 1'b0;
          target_ready_n_oe_out <= 1'b0;
          device_select_n_oe_out <= 1'b0;
          cycle_frame_n_oe_out <= 1'b0;
          if (cfg_hit) begin
            // claim in the second period after the address phase; the decode is registered
            st_q <= `PCIHS_ST_TGT;
            device_select_n_out <= 1'b0;
            device_select_n_oe_out <= 1'b1;
            target_ready_n_out <= 1'b1;
            target_ready_n_oe_out <= 1'b1;
            stop_request_n_out <= 1'b1;
            stop_request_n_oe_out <= 1'b1;
            cfg_write_out <= cfg_wr;
            wait_q <= TGT_WAIT;
            first_q <= 1'b0;
          end else if (ini_start_in && cycle_frame_n_in && initiator_ready_n_in) begin
            st_q <= `PCIHS_ST_INI;
            ini_busy_out <= 1'b1;
            cycle_frame_n_out <= 1'b0;
            cycle_frame_n_oe_out <= 1'b1;
            initiator_ready_n_out <= 1'b1;
            initiator_ready_n_oe_out <= 1'b1;
          end
        end
        `PCIHS_ST_TGT: begin
          // initiator ready only sampled here, never driven
          if (initiator_ready_n_in && !first_q) begin
            stop_request_n_out <= 1'b0;
          end
          if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
            target_ready_n_out <= 1'b1;
          end else if (target_ready_n_out) begin
            target_ready_n_out <= 1'b0;
            stop_request_n_out <= 1'b0;
          end else if (!initiator_ready_n_in) begin
            // one dword taken, then disconnect
            cfg_access_out <= 1'b1;
            first_q <= 1'b1;
            target_ready_n_out <= 1'b1;
            st_q <= `PCIHS_ST_TGT_END;
          end
        end
        `PCIHS_ST_TGT_END: begin
          if (cycle_frame_n_in) begin
            st_q <= `PCIHS_ST_IDLE;
            device_select_n_out <= 1'b1;
            stop_request_n_out <= 1'b1;
            target_ready_n_out <= 1'b1;
          end
        end
        `PCIHS_ST_INI: begin
          // wait state while the local side is not ready
          initiator_ready_n_out <= ~ini_ready_in;
          if (!stop_request_n_in) begin
            st_q <= `PCIHS_ST_INI_END;
            cycle_frame_n_out <= 1'b1;
            ini_stopped_out <= 1'b1;
          end else if (done && cycle_frame_n_out) begin
            // final phase taken; checked after stop but before the last flag so a held last flag cannot stall us
            st_q <= `PCIHS_ST_INI_END;
          end else if (ini_last_in && ini_ready_in) begin
            cycle_frame_n_out <= 1'b1;
          end
        end
        `PCIHS_ST_INI_END: begin
          st_q <= `PCIHS_ST_IDLE;
          ini_busy_out <= 1'b0;
          initiator_ready_n_out <= 1'b1;
          cycle_frame_n_oe_out <= 1'b0;
        end
        default: begin
          st_q <= `PCIHS_ST_IDLE;
        end
      endcase
    end
  end
endmodule // pcihs_core
`default_nettype wire

// >>> testbench/pcihs_core_asserts.sv
// checker on the pcihs_core ports
// assumes bound to each pcihs_core instance
`timescale 1ns/100ps
`default_nettype none
module pcihs_core_asserts #(parameter [3:0] TGT_WAIT = 4'h2) (
  input wire clock_in, arst_n_in, cycle_frame_n_in, initiator_ready_n_in,
  input wire target_ready_n_in, stop_request_n_in, init_dev_select_in,
  input wire [3:0] command_byte_enable_n_in,
  input wire cycle_frame_n_out, initiator_ready_n_oe_out, target_ready_n_out,
  input wire target_ready_n_oe_out, stop_request_n_oe_out, device_select_n_out,
  input wire device_select_n_oe_out, data_done_out, ini_stopped_out, ini_busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  a_claim_next: assert property ($fell(cycle_frame_n_in) && init_dev_select_in &&
    command_byte_enable_n_in[3:1] == 3'h5 |-> ##2 !device_select_n_out && device_select_n_oe_out)
    else $error("config access not claimed in time");
  a_no_claim: assert property ($fell(cycle_frame_n_in) && !init_dev_select_in |->
    ##2 !device_select_n_oe_out) else $error("claim without select");
  a_done_both: assert property (data_done_out |->
    !$past(initiator_ready_n_in) && !$past(target_ready_n_in)) else $error("done without ready");
  a_trdy_stretch: assert property ($rose(device_select_n_oe_out) |-> target_ready_n_out[*2])
    else $error("target ready not stretched");
  a_irdy_as_tgt: assert property (device_select_n_oe_out |-> !initiator_ready_n_oe_out)
    else $error("initiator ready driven as target");
  a_stop_frame: assert property (ini_busy_out && !cycle_frame_n_out && !stop_request_n_in |=>
    cycle_frame_n_out)
    else $error("frame not raised on stop");
  a_stop_end: assert property (ini_busy_out && !stop_request_n_in |-> ##[1:3] !ini_busy_out)
    else $error("transaction not ended on stop");
  a_stop_seen: assert property (ini_busy_out && !cycle_frame_n_out && !stop_request_n_in |->
    ##1 ini_stopped_out)
    else $error("stop not sampled");
  a_stop_tgt: assert property (stop_request_n_oe_out |-> device_select_n_oe_out)
    else $error("stop driven outside target role");
  a_float_idle: assert property (!ini_busy_out && !$past(ini_busy_out) && !device_select_n_oe_out
    && !$past(device_select_n_oe_out) |-> !initiator_ready_n_oe_out && !stop_request_n_oe_out
    && !target_ready_n_oe_out) else $error("output driven while idle");
endmodule // pcihs_core_asserts
bind pcihs_core pcihs_core_asserts #(.TGT_WAIT(TGT_WAIT)) u_chk (.clock_in, .arst_n_in,
  .cycle_frame_n_in, .initiator_ready_n_in, .target_ready_n_in, .stop_request_n_in,
  .init_dev_select_in, .command_byte_enable_n_in, .cycle_frame_n_out, .initiator_ready_n_oe_out,
  .target_ready_n_out, .target_ready_n_oe_out, .stop_request_n_oe_out, .device_select_n_out,
  .device_select_n_oe_out, .data_done_out, .ini_stopped_out, .ini_busy_out);
`default_nettype wire

// >>> testbench/pcihs_host_model.sv
// far-side pci agent: pull-ups, a target answering the device, host levels
// assumes the bench drives host levels just after rising edges
`timescale 1ns/100ps
`default_nettype none
module pcihs_host_model (
  input wire logic clock_in,
  input wire logic [3:0] dut_oe_in,
  input wire logic [3:0] dut_val_in,
  input wire logic host_frame_n_in, host_irdy_n_in, stop_en_in,
  output logic frame_n_out, irdy_n_out, trdy_n_out, stop_n_out
);
  logic tgt_q;
  // one cycle of decode before answering, like a slow real target
  always @(posedge clock_in) tgt_q <= dut_oe_in[3] | dut_oe_in[2];
  // released frame and irdy take the host levels; released trdy and stop come from the model target
  assign frame_n_out = dut_oe_in[3] ? dut_val_in[3] : host_frame_n_in;
  assign irdy_n_out = dut_oe_in[2] ? dut_val_in[2] : host_irdy_n_in;
  assign trdy_n_out = dut_oe_in[1] ? dut_val_in[1] : !tgt_q;
  assign stop_n_out = dut_oe_in[0] ? dut_val_in[0] : !(tgt_q && stop_en_in);
endmodule // pcihs_host_model
`default_nettype wire

// >>> testbench/pcihs_core_tb_top.sv
// bench for pcihs_core: config target cycles and initiator cycles
// assumes the host model on the far side
`timescale 1ns/100ps
`default_nettype none
module pcihs_core_tb_top;
  logic clock_in = 0, arst_n_in = 0, hf_n = 1, hi_n = 1, sel = 0, st = 0, start = 0, rdy = 0;
  logic last = 0;
  logic [3:0] cbe = 4'hF;
  wire logic [4:0] oe, val;
  wire logic fr_n, ir_n, tr_n, sp_n, acc, wr, done, stopped, busy;
  int mismatches = 0, compares = 0;
  always #2 clock_in = ~clock_in;
  pcihs_host_model i_host (.clock_in, .dut_oe_in(oe[4:1]), .dut_val_in(val[4:1]),
    .host_frame_n_in(hf_n), .host_irdy_n_in(hi_n), .stop_en_in(st), .frame_n_out(fr_n),
    .irdy_n_out(ir_n), .trdy_n_out(tr_n), .stop_n_out(sp_n));
  pcihs_core i_dut (.clock_in, .arst_n_in, .cycle_frame_n_in(fr_n), .initiator_ready_n_in(ir_n),
    .target_ready_n_in(tr_n), .stop_request_n_in(sp_n), .init_dev_select_in(sel),
    .command_byte_enable_n_in(cbe), .ini_start_in(start), .ini_ready_in(rdy), .ini_last_in(last),
    .cycle_frame_n_out(val[4]), .cycle_frame_n_oe_out(oe[4]), .initiator_ready_n_out(val[3]),
    .initiator_ready_n_oe_out(oe[3]), .target_ready_n_out(val[2]), .target_ready_n_oe_out(oe[2]),
    .stop_request_n_out(val[1]), .stop_request_n_oe_out(oe[1]), .device_select_n_out(val[0]),
    .device_select_n_oe_out(oe[0]), .cfg_access_out(acc), .cfg_write_out(wr),
    .data_done_out(done), .ini_stopped_out(stopped), .ini_busy_out(busy));
  task automatic cmp(input string nm, input logic [4:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cfg_cycle(input logic [3:0] cmd, input logic s, input int dly);
    int n;
    @(posedge clock_in) hf_n <= 0;
    cbe <= cmd;
    sel <= s;
    @(posedge clock_in) sel <= 0;
    repeat (2) @(posedge clock_in);
    #1 cmp("claim", {s, ~s}, {oe[0], val[0]});
    if (s) begin
      repeat (dly) @(posedge clock_in);
      hi_n <= 0;
      for (n = 0; n < 20 && acc !== 1'b1; n++) begin @(posedge clock_in); #1; end
      cmp("done", 1, acc);
      cmp("write", cmd[0], wr);
      cmp("stop", 2'h2, {oe[1], val[1]});
    end
    @(posedge clock_in) hf_n <= 1;
    @(posedge clock_in) hi_n <= 1;
    repeat (3) @(posedge clock_in);
    #1 cmp("float", 0, oe);
  endtask
  task automatic ini_cycle(input logic stp);
    int n;
    logic seen_s, seen_d;
    seen_s = 0;
    seen_d = 0;
    @(posedge clock_in) st <= stp;
    rdy <= 1;
    last <= !stp;
    start <= 1;
    for (n = 0; n < 10 && busy !== 1'b1; n++) begin @(posedge clock_in); #1; end
    start <= 0;
    cmp("irdy_oe", 1, oe[3]);
    for (n = 0; n < 20; n++) begin
      @(posedge clock_in);
      #1 seen_s |= stopped;
      seen_d |= done;
    end
    cmp("stopped", stp, seen_s);
    cmp("done", 1, seen_d);
    cmp("float", 0, {oe, busy});
    rdy <= 0;
    last <= 0;
    st <= 0;
  endtask
  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clock_in);
    arst_n_in <= 1;
    #1 cmp("reset", 5'h1F, val);
    cfg_cycle(4'hA, 1, 0);
    cfg_cycle(4'hB, 1, 6);
    cfg_cycle(4'hB, 0, 0);
    ini_cycle(0);
    ini_cycle(1);
    tally_and_finish;
  end
endmodule // pcihs_core_tb_top
`default_nettype wire
